// [rtl/cop_dp_regs.vh]
// Operation codes, unit codes and field widths for the constant, OR and pack datapath
`ifndef COP_DP_REGS_VH
`define COP_DP_REGS_VH
`define COP_OP_W            3
`define COP_OP_MOVE_CONST   3'h0
`define COP_OP_MOVE_LOW     3'h1
`define COP_OP_OR           3'h2
`define COP_OP_PACK_LO      3'h3
`define COP_OP_PACK_HI      3'h4
`define COP_OP_PACK_HB      3'h5
`define COP_OP_PACK_HL      3'h6
`define COP_UNIT_W          2
`define COP_UNIT_LOGIC      2'h0
`define COP_UNIT_SHIFT      2'h1
`define COP_UNIT_DATA       2'h2
`define COP_IMM5_W          5
`define COP_IMM16_W         16
`define COP_DATA_W          32
`define COP_DST_W           5
`define COP_RESULT_RST      32'h00000000
`endif

// [rtl/cop_sext.v]
// Sign extension of a narrow immediate to the datapath width
`timescale 1ns/1ps
module cop_sext #(
   parameter IN_W  = 5,
   parameter OUT_W = 32
) (
   input  wire [IN_W-1:0]  imm_i,
   output wire [OUT_W-1:0] ext_o
);
   assign ext_o = {{(OUT_W-IN_W){imm_i[IN_W-1]}}, imm_i};
endmodule // cop_sext

// [rtl/cop_pack.v]
// Half-word and byte packing network
`timescale 1ns/1ps
`include "cop_dp_regs.vh"
module cop_pack (
   input  wire [`COP_OP_W-1:0]   op_i,
   input  wire [`COP_DATA_W-1:0] a_i,
   input  wire [`COP_DATA_W-1:0] b_i,
   output reg  [`COP_DATA_W-1:0] res_o
);
   always @*
   begin
      case (op_i)
         `COP_OP_PACK_LO: res_o = {a_i[15:0], b_i[15:0]};                      // [RULE11]
         `COP_OP_PACK_HI: res_o = {a_i[31:16], b_i[31:16]};                    // [RULE12]
         `COP_OP_PACK_HB: res_o = {a_i[31:24], a_i[15:8], b_i[31:24], b_i[15:8]}; // [RULE13]
         `COP_OP_PACK_HL: res_o = {a_i[31:16], b_i[15:0]};                     // [RULE14]
         default:         res_o = `COP_RESULT_RST;
      endcase
   end
endmodule // cop_pack

// [rtl/cop_datapath.v]
// Constant-load, OR and pack execution datapath, single cycle, predicated
//
// How it works
// RULE1 - Constant loads sign-extend their immediate to 32 bits; the shift unit uses 16 bits.
// RULE2 - On the logic or data unit the constant load takes only a 5-bit signed immediate.
// RULE3 - The data-unit constant load takes its immediate from the first-source field.
// RULE4 - Logic and data units run only the plain constant load; shift runs plain and low.
// RULE5 - The low constant load gives exactly the plain load's result.
// RULE6 - Constant loads write only when the predicate is true, else change nothing.
// RULE7 - Every operation finishes in one execute cycle, visible one cycle later.
// RULE8 - OR writes the bitwise OR of both sources only when the predicate is true.
// RULE9 - The immediate OR sign-extends the 5-bit immediate to 32 bits first.
// RULE10 - OR in register and immediate forms runs on data, logic and shift units.
// RULE11 - Pack low halves puts first-source low half high and second-source low half low.
// RULE12 - Pack high halves puts first-source high half high and second-source high half low.
// RULE13 - Pack high bytes, logic unit only, takes bytes 3,1 of first then 3,1 of second.
// RULE14 - Pack high-low puts first-source high half high and second-source low half low.
// RULE15 - The cross-path bit takes the second source from the opposite register file.
`timescale 1ns/1ps
`include "cop_dp_regs.vh"
module cop_datapath (
   input  wire                     clk_i,
   input  wire                     nrst_i,
   input  wire                     issue_i,
   input  wire [`COP_OP_W-1:0]     op_i,
   input  wire [`COP_UNIT_W-1:0]   unit_i,
   input  wire                     pred_true_i,
   input  wire                     use_imm_i,
   input  wire                     cross_path_i,
   input  wire [`COP_DST_W-1:0]    dst_addr_i,
   input  wire [`COP_DATA_W-1:0]   first_source_operand_i,
   input  wire [`COP_DATA_W-1:0]   second_source_operand_i,
   input  wire [`COP_DATA_W-1:0]   cross_source_operand_i,
   input  wire [`COP_IMM5_W-1:0]   signed_imm_five_i,
   input  wire [`COP_IMM5_W-1:0]   first_source_field_i,
   input  wire [`COP_IMM16_W-1:0]  signed_imm_sixteen_i,
   output reg                      wr_en_o,
   output reg  [`COP_DST_W-1:0]    wr_addr_o,
   output reg  [`COP_DATA_W-1:0]   wr_data_o,
   output reg                      illegal_o
);
   ////////////////////////////////////////////////////////////////////////////
   wire [`COP_DATA_W-1:0] imm5_ext;
   wire [`COP_DATA_W-1:0] fld5_ext;
   wire [`COP_DATA_W-1:0] imm16_ext;
   wire [`COP_DATA_W-1:0] pack_res;
   reg  [`COP_DATA_W-1:0] src_b;
   reg  [`COP_DATA_W-1:0] src_a;
   wire [`COP_DATA_W-1:0] or_res;
   reg  [`COP_DATA_W-1:0] const_res;
   wire [`COP_DATA_W-1:0] result;
   wire                   legal;

   // One-hot opcode and unit decode
   reg                    op_move_const;
   reg                    op_move_low;
   reg                    op_or;
   reg                    op_pack_lo;
   reg                    op_pack_hi;
   reg                    op_pack_hb;
   reg                    op_pack_hl;
   reg                    on_logic;
   reg                    on_shift;
   reg                    on_data;
   wire                   on_any_unit;
   wire                   op_const_any;
   wire                   op_pack_half;
   wire                   op_pack_any;

   // Legality terms, one per operation group
   wire                   legal_const;
   wire                   legal_low;
   wire                   legal_or;
   wire                   legal_half;
   wire                   legal_byte;

   // Next values of the write-back stage
   reg                    wr_en_d;
   reg  [`COP_DST_W-1:0]  wr_addr_d;
   reg  [`COP_DATA_W-1:0] wr_data_d;
   reg                    illegal_d;

   cop_sext #(.IN_W(`COP_IMM5_W), .OUT_W(`COP_DATA_W)) u_sext5 (
      .imm_i (signed_imm_five_i),
      .ext_o (imm5_ext)
   );
   cop_sext #(.IN_W(`COP_IMM5_W), .OUT_W(`COP_DATA_W)) u_sextf (
      .imm_i (first_source_field_i),
      .ext_o (fld5_ext)
   );
   cop_sext #(.IN_W(`COP_IMM16_W), .OUT_W(`COP_DATA_W)) u_sext16 (
      .imm_i (signed_imm_sixteen_i),
      .ext_o (imm16_ext)
   );

   // Cross-path mux sits on the second source only, as in the register file ports
   always @*
   begin
      if (cross_path_i)
         src_b = cross_source_operand_i;  // [RULE15]
      else
         src_b = second_source_operand_i;
   end

   // The immediate form of OR replaces the first source with the extended 5-bit immediate
   always @*
   begin
      if (use_imm_i)
         src_a = imm5_ext;  // [RULE9]
      else
         src_a = first_source_operand_i;
   end

   cop_pack u_pack (
      .op_i  (op_i),
      .a_i   (first_source_operand_i),
      .b_i   (src_b),
      .res_o (pack_res)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Opcode decode; a code with no operation decodes to nothing and is refused
   always @*
   begin
      op_move_const = 1'b0;
      op_move_low   = 1'b0;
      op_or         = 1'b0;
      op_pack_lo    = 1'b0;
      op_pack_hi    = 1'b0;
      op_pack_hb    = 1'b0;
      op_pack_hl    = 1'b0;
      case (op_i)
         `COP_OP_MOVE_CONST:
         begin
            op_move_const = 1'b1;
         end

         `COP_OP_MOVE_LOW:
         begin
            op_move_low = 1'b1;
         end

         `COP_OP_OR:
         begin
            op_or = 1'b1;
         end

         `COP_OP_PACK_LO:
         begin
            op_pack_lo = 1'b1;
         end

         `COP_OP_PACK_HI:
         begin
            op_pack_hi = 1'b1;
         end

         `COP_OP_PACK_HB:
         begin
            op_pack_hb = 1'b1;
         end

         `COP_OP_PACK_HL:
         begin
            op_pack_hl = 1'b1;
         end

         default:
         begin
            op_move_const = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Unit decode; the fourth unit code names no unit and refuses everything
   always @*
   begin
      on_logic = 1'b0;
      on_shift = 1'b0;
      on_data  = 1'b0;
      case (unit_i)
         `COP_UNIT_LOGIC:
         begin
            on_logic = 1'b1;
         end

         `COP_UNIT_SHIFT:
         begin
            on_shift = 1'b1;
         end

         `COP_UNIT_DATA:
         begin
            on_data = 1'b1;
         end

         default:
         begin
            on_logic = 1'b0;
         end
      endcase
   end

   assign on_any_unit  = on_logic | on_shift | on_data;
   assign op_const_any = op_move_const | op_move_low;
   assign op_pack_half = op_pack_lo | op_pack_hi | op_pack_hl;
   assign op_pack_any  = op_pack_half | op_pack_hb;

   ////////////////////////////////////////////////////////////////////////////
   // Which unit may carry which operation
   assign legal_const = op_move_const & on_any_unit;  // [RULE4]
   assign legal_low   = op_move_low & on_shift;  // [RULE4]
   assign legal_or    = op_or & on_any_unit;  // [RULE10]
   assign legal_half  = op_pack_half & (on_logic | on_shift);  // [RULE11] [RULE12] [RULE14]
   assign legal_byte  = op_pack_hb & on_logic;  // [RULE13]
   assign legal       = legal_const | legal_low | legal_or | legal_half | legal_byte;

   ////////////////////////////////////////////////////////////////////////////
   // Constant immediate; the field width follows the unit carrying the load
   always @*
   begin
      const_res = imm5_ext;
      case (unit_i)
         `COP_UNIT_SHIFT:
         begin
            const_res = imm16_ext;  // [RULE1] [RULE5]
         end

         `COP_UNIT_DATA:
         begin
            const_res = fld5_ext;  // [RULE3] [RULE2]
         end

         `COP_UNIT_LOGIC:
         begin
            const_res = imm5_ext;  // [RULE2]
         end

         default:
         begin
            const_res = imm5_ext;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result select, one AND-OR mux per byte lane; the unused opcode yields zero, a refused unit pairing still drives its operation's result
   assign or_res = src_a | src_b;  // [RULE8]

   localparam LANE_N = `COP_DATA_W / 8;
   genvar lane;
   generate
      for (lane = 0; lane < LANE_N; lane = lane + 1)
      begin : g_lane
         wire [7:0] const_byte;
         wire [7:0] or_byte;
         wire [7:0] pack_byte;
         assign const_byte = {8{op_const_any}} & const_res[8*lane+7:8*lane];
         assign or_byte    = {8{op_or}} & or_res[8*lane+7:8*lane];
         assign pack_byte  = {8{op_pack_any}} & pack_res[8*lane+7:8*lane];
         assign result[8*lane+7:8*lane] = const_byte | or_byte | pack_byte;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next values; a false predicate or a refused operation writes nothing
   always @*
   begin
      wr_en_d   = 1'b0;
      wr_addr_d = dst_addr_i;
      wr_data_d = result;
      illegal_d = 1'b0;
      if (issue_i)
      begin
         if (!legal)
         begin
            illegal_d = 1'b1;
         end
         else if (pred_true_i)
         begin
            wr_en_d = 1'b1;  // [RULE6] [RULE8]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Single write-back stage, so a result is visible one cycle after issue
   always @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         wr_en_o   <= 1'b0;
         wr_addr_o <= 5'h00;
         wr_data_o <= `COP_RESULT_RST;
         illegal_o <= 1'b0;
      end
      else
      begin
         wr_en_o   <= wr_en_d;  // [RULE7]
         wr_addr_o <= wr_addr_d;
         wr_data_o <= wr_data_d;  // [RULE7]
         illegal_o <= illegal_d;
      end
   end
endmodule // cop_datapath

// [verification/cop_dp_chk.sv]
// Concurrent checks on the datapath result and strobe ports
`timescale 1ns/1ps
module cop_dp_chk (
   input wire        clk_i, nrst_i, issue_i, pred_true_i, use_imm_i, cross_path_i,
   input wire [2:0]  op_i,
   input wire [1:0]  unit_i,
   input wire [31:0] first_source_operand_i, second_source_operand_i, wr_data_o,
   input wire        wr_en_o, illegal_o
);
   reg  [31:0] a_q, b_q;
   wire        go = issue_i && pred_true_i && !cross_path_i;
   always @(posedge clk_i)
   begin
      a_q <= first_source_operand_i;
      b_q <= second_source_operand_i;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   chk_pred_false_quiet: assert property (issue_i && !pred_true_i |=> !wr_en_o)
      else $error("write under false predicate");
   chk_or_reg_value: assert property (go && op_i == 3'h2 && !use_imm_i && unit_i != 2'h3
      |=> wr_en_o && wr_data_o == (a_q | b_q)) else $error("or result wrong");
   chk_pack_low: assert property (go && op_i == 3'h3 && unit_i < 2'h2
      |=> wr_data_o == {a_q[15:0], b_q[15:0]}) else $error("pack low wrong");
   chk_pack_high: assert property (go && op_i == 3'h4 && unit_i < 2'h2
      |=> wr_data_o == {a_q[31:16], b_q[31:16]}) else $error("pack high wrong");
   chk_pack_hl: assert property (go && op_i == 3'h6 && unit_i < 2'h2
      |=> wr_data_o == {a_q[31:16], b_q[15:0]}) else $error("pack high low wrong");
   chk_bytes_unit: assert property (go && op_i == 3'h5 && unit_i != 2'h0
      |=> illegal_o && !wr_en_o) else $error("byte pack off logic unit");
   chk_move_low_unit: assert property (go && op_i == 3'h1 && unit_i != 2'h1
      |=> illegal_o) else $error("low load off shift unit");
   chk_one_cycle_answer: assert property (wr_en_o |-> $past(issue_i) && !illegal_o)
      else $error("write not one cycle after issue");
endmodule // cop_dp_chk
bind cop_datapath cop_dp_chk i_chk (.*);

// [verification/cop_rf_model.sv]
// Destination register file that the datapath writes into
`timescale 1ns/1ps
module cop_rf_model (
   input  wire        clk_i,
   input  wire        wr_en_i,
   input  wire [4:0]  wr_addr_i,
   input  wire [31:0] wr_data_i,
   input  wire [4:0]  rd_addr_i,
   output wire [31:0] rd_data_o
);
   reg [31:0] rf_q [0:31];
   // Lands at the strobe's edge, so an op issued one cycle on reads it
   always @(posedge clk_i) if (wr_en_i) rf_q[wr_addr_i] <= wr_data_i;
   assign rd_data_o = rf_q[rd_addr_i];
endmodule // cop_rf_model

// [verification/tb_top.sv]
// Self-checking bench for the constant, OR and pack datapath
`timescale 1ns/1ps
module tb_top;
   reg         clk_i, nrst_i, is, pr, ui, cp;
   reg  [2:0]  op;
   reg  [1:0]  un;
   reg  [4:0]  i5, f5;
   reg  [15:0] i16;
   reg  [31:0] a, b, x;
   wire        wr_en_o, illegal_o;
   wire [4:0]  wr_addr_o;
   wire [31:0] wr_data_o, rd;
   integer     bad_count = 0, tests_run = 0, cyc = 0;
   cop_datapath i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .issue_i(is), .op_i(op), .unit_i(un),
      .pred_true_i(pr), .use_imm_i(ui), .cross_path_i(cp), .dst_addr_i(5'h03),
      .first_source_operand_i(a), .second_source_operand_i(b), .cross_source_operand_i(x),
      .signed_imm_five_i(i5), .first_source_field_i(f5), .signed_imm_sixteen_i(i16),
      .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .illegal_o(illegal_o));
   cop_rf_model i_rf (.clk_i(clk_i), .wr_en_i(wr_en_o), .wr_addr_i(wr_addr_o),
      .wr_data_i(wr_data_o), .rd_addr_i(5'h03), .rd_data_o(rd));
   task chk(input [31:0] s, input [31:0] e);
      begin
         tests_run = tests_run + 1;
         if (s !== e)
         begin
            bad_count = bad_count + 1;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
         end
      end
   endtask
   task summarize;
      begin
         $display("mismatches %0d compares %0d", bad_count, tests_run);
         if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task run(input [2:0] o, input [1:0] u, input [31:0] e, input il);
      begin
         op = o;
         un = u;
         is = 1'b1;
         @(posedge clk_i) #1 is = 1'b0;
         chk({30'h0, wr_en_o, illegal_o}, {30'h0, pr & ~il, il});
         chk({27'h0, wr_addr_o}, 32'h00000003);
         @(posedge clk_i) #1 chk(rd, e);
      end
   endtask
   task t_const;
      begin
         i16 = 16'h8000;
         run(3'h0, 2'h1, 32'hffff8000, 1'b0);
         i16 = 16'h5678;
         run(3'h1, 2'h1, 32'h00005678, 1'b0);
         run(3'h0, 2'h0, 32'hfffffffb, 1'b0);
         run(3'h0, 2'h2, 32'h0000000e, 1'b0);
         run(3'h1, 2'h2, 32'h0000000e, 1'b1);
         pr = 1'b0;
         run(3'h0, 2'h1, 32'h0000000e, 1'b0);
         pr = 1'b1;
      end
   endtask
   task t_or;
      begin
         a = 32'h08a3a49f;
         b = 32'h00ff375a;
         run(3'h2, 2'h0, 32'h08ffb7df, 1'b0);
         ui = 1'b1;
         i5 = 5'h14;
         b = 32'h00003a41;
         run(3'h2, 2'h2, 32'hfffffff5, 1'b0);
         ui = 1'b0;
         cp = 1'b1;
         x = 32'h00ff375a;
         run(3'h2, 2'h1, 32'h08ffb7df, 1'b0);
         cp = 1'b0;
      end
   endtask
   task t_pack;
      begin
         a = 32'h3789f23a;
         b = 32'h04b84975;
         run(3'h3, 2'h0, 32'hf23a4975, 1'b0);
         run(3'h4, 2'h1, 32'h378904b8, 1'b0);
         run(3'h5, 2'h0, 32'h37f20449, 1'b0);
         run(3'h5, 2'h1, 32'h37f20449, 1'b1);
         run(3'h6, 2'h1, 32'h37894975, 1'b0);
      end
   endtask
   task t_refuse;
      begin
         run(3'h7, 2'h0, 32'h37894975, 1'b1);
         run(3'h2, 2'h3, 32'h37894975, 1'b1);
         run(3'h3, 2'h2, 32'h37894975, 1'b1);
      end
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Cap the run at 2000 cycles and count reaching the cap as a mismatch
   always @(posedge clk_i)
   begin
      cyc = cyc + 1;
      if (cyc == 2000)
      begin
         bad_count = bad_count + 1;
         summarize;
      end
   end
   initial
   begin
      {nrst_i, is, ui, cp, op, un, i16, a, b, x} = 0;
      {pr, i5, f5} = {1'b1, 5'h1b, 5'h0e};
      repeat (12) @(posedge clk_i);
      #1 chk({31'h0, wr_en_o}, 32'h0);
      nrst_i = 1'b1;
      t_const;
      t_or;
      t_pack;
      t_refuse;
      summarize;
   end
endmodule // tb_top
